// ===== core/odc_driver_ctrl.sv
// How it works
// RULE1: ready register reads 0x0f once ready
// RULE2: ready register mirrored on every page
// RULE3: kill bit 0 disables all outputs
// RULE4: kill bit 1 leaves per-output control
// RULE5: power-down bit 1 powers down driver
// RULE6: output-enable bit 1 enables output
// RULE7: force bit selects divide by two
// RULE8: divider value zero is not divide-by-two
// RULE9: force bit ignores programmed divider value
// RULE10: style codes 1,2,4 decode; others reserved
// RULE11: glitchless mode syncs changes to output clock
// RULE12: disabled output rests at idle level
// RULE13: swing and common level only differential
// RULE14: toggle only when killn, enabled, powered up
// RULE15: without glitchless, changes apply at once
module odc_driver_ctrl #(
	parameter int DIV_W = 8 // width of programmed divider
) (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic [15:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after read
	input wire logic src_clk_i, // divider source clock (sampled)
	output logic clk_out_o, // output clock level
	output logic drv_active_o, // driver enabled and powered up
	output logic drv_power_down_o, // driver powered down
	output logic [2:0] style_o, // valid style, 0 when reserved
	output logic [3:0] common_level_o, // effective common level
	output logic [2:0] swing_o, // effective swing
	output logic style_reserved_o // style code is reserved
);
	// ============================================================
	// elaboration check
	if (DIV_W < 1 || DIV_W > 8) begin : g_div_w_chk
		$error("DIV_W must be 1..8");
	end

	// ============================================================
	// register file
	odc_pkg::odc_bus_t bus;
	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	logic [7:0] kill_reg, kill_next;
	logic [7:0] pwr_reg, pwr_next;
	logic [7:0] style_reg, style_next;
	logic [7:0] swing_reg, swing_next;
	logic [7:0] rdiv_reg, rdiv_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [3:0] rdy_cnt_reg, rdy_cnt_next;
	logic ready;

	assign ready = (rdy_cnt_reg == 4'(odc_pkg::READY_DLY_CYC));

	always_comb begin
		kill_next = kill_reg;
		pwr_next = pwr_reg;
		style_next = style_reg;
		swing_next = swing_reg;
		rdiv_next = rdiv_reg;
		rdata_next = 8'h00;
		rdy_cnt_next = ready ? rdy_cnt_reg : rdy_cnt_reg + 4'h1;
		if (bus.wr) begin
			case (bus.addr)
				odc_pkg::KILL_OFS: kill_next = {7'h00, bus.wdata[odc_pkg::KILL_BIT]};
				odc_pkg::PWR_OFS: pwr_next = {5'h00, bus.wdata[2:0]};
				odc_pkg::STYLE_OFS: style_next = bus.wdata;
				odc_pkg::SWING_OFS: swing_next = {1'b0, bus.wdata[6:0]};
				odc_pkg::RDIV_OFS: rdiv_next = bus.wdata;
				default: ;
			endcase
		end
		if (bus.rd) begin
			// ready byte decodes on the low byte only, any page
			if (bus.addr[7:0] == odc_pkg::READY_OFS[7:0]) begin
				rdata_next = ready ? odc_pkg::READY_VAL : odc_pkg::NOT_READY_VAL; // see RULE1 see RULE2
			end else begin
				case (bus.addr)
					odc_pkg::KILL_OFS: rdata_next = kill_reg;
					odc_pkg::PWR_OFS: rdata_next = pwr_reg;
					odc_pkg::STYLE_OFS: rdata_next = style_reg;
					odc_pkg::SWING_OFS: rdata_next = swing_reg;
					odc_pkg::RDIV_OFS: rdata_next = rdiv_reg;
					default: rdata_next = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			kill_reg <= odc_pkg::KILL_RST;
			pwr_reg <= odc_pkg::PWR_RST;
			style_reg <= odc_pkg::STYLE_RST;
			swing_reg <= odc_pkg::SWING_RST;
			rdiv_reg <= odc_pkg::RDIV_RST;
			rdata_reg <= 8'h00;
			rdy_cnt_reg <= 4'h0;
		end else begin
			kill_reg <= kill_next;
			pwr_reg <= pwr_next;
			style_reg <= style_next;
			swing_reg <= swing_next;
			rdiv_reg <= rdiv_next;
			rdata_reg <= rdata_next;
			rdy_cnt_reg <= rdy_cnt_next;
		end
	end
	assign rdata_o = rdata_reg;

	// ============================================================
	// source clock synchroniser
	logic src_s1_reg, src_s2_reg, src_s3_reg;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_s1_reg <= 1'b0;
			src_s2_reg <= 1'b0;
			src_s3_reg <= 1'b0;
		end else begin
			src_s1_reg <= src_clk_i;
			src_s2_reg <= src_s1_reg;
			src_s3_reg <= src_s2_reg;
		end
	end
	logic src_rise;
	assign src_rise = src_s2_reg & ~src_s3_reg;

	// ============================================================
	// output R divider
	logic force2, glitchless, div_run;
	logic [DIV_W-1:0] div_val;
	logic [DIV_W-1:0] div_cnt_reg, div_cnt_next;
	logic div_clk_reg, div_clk_next;
	logic [DIV_W-1:0] half_cnt;

	assign force2 = pwr_reg[odc_pkg::FORCE2_BIT];
	assign glitchless = style_reg[odc_pkg::SYNC_BIT];
	assign div_val = rdiv_reg[DIV_W-1:0];
	// force bit overrides the value; a zero value alone parks the divider
	assign half_cnt = force2 ? DIV_W'(0) : div_val; // see RULE7 see RULE9
	assign div_run = force2 | (div_val != '0); // see RULE8

	always_comb begin
		div_cnt_next = div_cnt_reg;
		div_clk_next = div_clk_reg;
		if (src_rise && div_run) begin
			if (div_cnt_reg >= half_cnt) begin
				div_cnt_next = '0;
				div_clk_next = ~div_clk_reg;
			end else begin
				div_cnt_next = div_cnt_reg + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_cnt_reg <= '0;
			div_clk_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_next;
			div_clk_reg <= div_clk_next;
		end
	end

	// ============================================================
	// enable and power-down application
	logic oe_req, pdn_req;
	logic oe_eff_reg, oe_eff_next;
	logic pdn_eff_reg, pdn_eff_next;
	logic div_clk_d_reg;
	logic out_fall;

	assign oe_req = pwr_reg[odc_pkg::OE_BIT] & kill_reg[odc_pkg::KILL_BIT]; // see RULE3 see RULE4 see RULE6
	assign pdn_req = pwr_reg[odc_pkg::PDN_BIT]; // see RULE5
	assign out_fall = div_clk_d_reg & ~div_clk_reg;

	always_comb begin
		oe_eff_next = oe_eff_reg;
		pdn_eff_next = pdn_eff_reg;
		if (!glitchless || out_fall) begin
			// glitchless waits for the output's falling edge
			oe_eff_next = oe_req; // see RULE11 see RULE15
			pdn_eff_next = pdn_req; // see RULE11 see RULE15
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			oe_eff_reg <= 1'b0;
			pdn_eff_reg <= 1'b0;
			div_clk_d_reg <= 1'b0;
		end else begin
			oe_eff_reg <= oe_eff_next;
			pdn_eff_reg <= pdn_eff_next;
			div_clk_d_reg <= div_clk_reg;
		end
	end

	// ============================================================
	// output driver
	logic [1:0] idle_lvl;
	logic active;
	odc_pkg::odc_style_t sty;
	assign idle_lvl = style_reg[odc_pkg::IDLE_LSB +: 2];
	assign active = oe_eff_reg & ~pdn_eff_reg; // see RULE14

	always_comb begin
		sty.diff_en = (style_reg[2:0] == odc_pkg::STYLE_DIFF); // see RULE10
		sty.lpdiff_en = (style_reg[2:0] == odc_pkg::STYLE_LPDIFF);
		sty.cmos_en = (style_reg[2:0] == odc_pkg::STYLE_CMOS);
		sty.common_level = '0;
		sty.swing = '0;
		if (sty.diff_en || sty.lpdiff_en) begin
			sty.common_level = swing_reg[odc_pkg::CM_LSB +: 4]; // see RULE13
			sty.swing = swing_reg[odc_pkg::SWING_LSB +: 3]; // see RULE13
		end
	end

	logic clk_out_reg, clk_out_next;
	always_comb begin
		if (active)
			clk_out_next = div_clk_reg;
		else if (pdn_eff_reg)
			clk_out_next = 1'b0;
		else
			clk_out_next = (idle_lvl == 2'h1); // see RULE12
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			clk_out_reg <= 1'b0;
		else
			clk_out_reg <= clk_out_next;
	end

	assign clk_out_o = clk_out_reg;
	assign drv_active_o = active;
	assign drv_power_down_o = pdn_eff_reg;
	assign style_o = (sty.diff_en | sty.lpdiff_en | sty.cmos_en) ? style_reg[2:0] : 3'h0;
	assign style_reserved_o = ~(sty.diff_en | sty.lpdiff_en | sty.cmos_en);
	assign common_level_o = sty.common_level;
	assign swing_o = sty.swing;

	// ============================================================
	// checks
	property p_ready_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		(rd_i && addr_i[7:0] == 8'hfe && ready) |=> (rdata_o == 8'h0f);
	endproperty
	a_ready_read: assert property (p_ready_read) else $error("ready byte wrong"); // see RULE1

	property p_ready_page;
		@(posedge clk_i) disable iff (!rst_n_i)
		(rd_i && addr_i[7:0] == 8'hfe && addr_i[15:8] != 8'h00 && ready) |=> (rdata_o == 8'h0f);
	endproperty
	a_ready_page: assert property (p_ready_page) else $error("ready not mirrored"); // see RULE2

	property p_kill;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!kill_reg[0] && !glitchless) |=> !drv_active_o;
	endproperty
	a_kill: assert property (p_kill) else $error("kill did not disable"); // see RULE3

	property p_enable;
		@(posedge clk_i) disable iff (!rst_n_i)
		(kill_reg[0] && pwr_reg[1:0] == 2'b10 && !glitchless) |=> drv_active_o;
	endproperty
	a_enable: assert property (p_enable) else $error("output not enabled"); // see RULE4

	property p_pdn;
		@(posedge clk_i) disable iff (!rst_n_i)
		drv_power_down_o |=> !clk_out_o;
	endproperty
	a_pdn: assert property (p_pdn) else $error("active while powered down"); // see RULE5

	property p_oe_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!pwr_reg[1] && !glitchless) |=> !drv_active_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("active while disabled"); // see RULE6

	property p_force2;
		@(posedge clk_i) disable iff (!rst_n_i)
		(force2 && src_rise) |=> (div_clk_reg != $past(div_clk_reg));
	endproperty
	a_force2: assert property (p_force2) else $error("force divide not by two"); // see RULE7

	property p_rdiv_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!force2 && div_val == '0) |=> (div_clk_reg == $past(div_clk_reg));
	endproperty
	a_rdiv_zero: assert property (p_rdiv_zero) else $error("zero divider value toggled"); // see RULE8

	property p_idle;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!drv_active_o && !drv_power_down_o && idle_lvl == 2'h1) |=> clk_out_o;
	endproperty
	a_idle: assert property (p_idle) else $error("idle level wrong"); // see RULE12

	property p_swing;
		@(posedge clk_i) disable iff (!rst_n_i)
		(style_reg[2:0] == 3'h4) |-> (swing_o == 3'h0 && common_level_o == 4'h0);
	endproperty
	a_swing: assert property (p_swing) else $error("swing applied in cmos"); // see RULE13

	property p_sync_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(glitchless && !out_fall) |=> (oe_eff_reg == $past(oe_eff_reg));
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("change off output edge"); // see RULE11
endmodule // odc_driver_ctrl

// ===== core/odc_pkg.sv
package odc_pkg;
	// register offsets
	localparam logic [15:0] READY_OFS = 16'h00fe;
	localparam logic [15:0] KILL_OFS = 16'h0102;
	localparam logic [15:0] PWR_OFS = 16'h0103;
	localparam logic [15:0] STYLE_OFS = 16'h0104;
	localparam logic [15:0] SWING_OFS = 16'h0105;
	localparam logic [15:0] RDIV_OFS = 16'h0180;
	localparam logic [7:0] PAGE_MASK = 8'hff;
	// values
	localparam logic [7:0] READY_VAL = 8'h0f;
	localparam logic [7:0] NOT_READY_VAL = 8'h00;
	localparam logic [7:0] KILL_RST = 8'h00;
	localparam logic [7:0] PWR_RST = 8'h00;
	localparam logic [7:0] STYLE_RST = 8'h00;
	localparam logic [7:0] SWING_RST = 8'h00;
	localparam logic [7:0] RDIV_RST = 8'h00;
	// field positions
	localparam int PDN_BIT = 0;
	localparam int OE_BIT = 1;
	localparam int FORCE2_BIT = 2;
	localparam int SYNC_BIT = 3;
	localparam int KILL_BIT = 0;
	localparam int STYLE_LSB = 0;
	localparam int IDLE_LSB = 4;
	localparam int CM_LSB = 0;
	localparam int SWING_LSB = 4;
	// style codes
	localparam logic [2:0] STYLE_DIFF = 3'h1;
	localparam logic [2:0] STYLE_LPDIFF = 3'h2;
	localparam logic [2:0] STYLE_CMOS = 3'h4;
	// cycles from reset release until ready
	localparam int READY_DLY_CYC = 8;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} odc_bus_t;

	typedef struct packed {
		logic diff_en;
		logic lpdiff_en;
		logic cmos_en;
		logic [3:0] common_level;
		logic [2:0] swing;
	} odc_style_t;
endpackage

// ===== tb/odc_src_model.sv
// =====================================
// source clock and downstream load
module odc_src_model #(
	parameter int SRC_HALF = 20 // half period of source clock in ns
) (
	output logic src_clk_o, // free running divider source clock
	input wire logic clk_out_i, // generated output clock seen by the load
	output time per_o // last measured output clock period
);
	timeunit 1ns;
	timeprecision 1ps;
	time last = 0;
	initial begin
		src_clk_o = 1'b0;
		forever #(SRC_HALF) src_clk_o = ~src_clk_o;
	end
	// the load only observes rising edges
	always @(posedge clk_out_i) begin
		per_o = $time - last;
		last = $time;
	end
endmodule // odc_src_model

// ===== tb/tb_output_driver_control.sv
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
// =====================================
// bench top
module tb_output_driver_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic src_clk;
	logic clk_out_o, drv_active_o, drv_power_down_o, style_reserved_o;
	logic [2:0] style_o, swing_o;
	logic [3:0] common_level_o;
	time per;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	int err_total = 0;
	int num_checks = 0;
	logic [7:0] r;
	logic ok;
	int out_edges = 0;
	int n0;
	logic [15:0] odc_reg_list[5] = '{16'h0102, 16'h0103, 16'h0104, 16'h0105, 16'h0180};

	always #2 clk_i = ~clk_i;

	odc_driver_ctrl #(.DIV_W(8)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_clk_i(src_clk),
		.clk_out_o(clk_out_o), .drv_active_o(drv_active_o), .drv_power_down_o(drv_power_down_o),
		.style_o(style_o), .common_level_o(common_level_o), .swing_o(swing_o),
		.style_reserved_o(style_reserved_o));
	odc_src_model #(.SRC_HALF(20)) src_u (.src_clk_o(src_clk), .clk_out_i(clk_out_o), .per_o(per));

	// =====================================
	// read data monitor
	always @(posedge clk_i) begin
		rd_d <= rd_i;
		if (rd_d) begin
			`CHK(rdata_o, exp_q.pop_front())
		end
	end

	always @(posedge clk_out_o) out_edges++;

	// one access launched on a clock edge, strobe dropped at the next
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		if (w) wr_i <= 1'b1;
		else begin
			rd_i <= 1'b1;
			exp_q.push_back(d);
		end
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
	endtask

	task settle();
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	task results();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		results();
	end

	// =====================================
	// main sequence
	initial begin
		void'($urandom(62));
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		acc(0, 16'h00fe, 8'h00);
		repeat (12) @(posedge clk_i);
		acc(0, 16'h00fe, 8'h0f);
		acc(0, 16'h01fe, 8'h0f);
		acc(0, 16'h05fe, 8'h0f);
		// only now the host touches other registers
		foreach (odc_reg_list[i]) acc(0, odc_reg_list[i], 8'h00);
		acc(0, 16'h0107, 8'h00);
		acc(1, 16'h0107, 8'h5a);
		acc(0, 16'h0107, 8'h00);
		settle();
		`CHK(drv_active_o, 1'b0)
		acc(1, 16'h0102, 8'h01);
		acc(1, 16'h0104, 8'h01);
		acc(1, 16'h0180, 8'h03);
		acc(1, 16'h0103, 8'h02);
		settle();
		`CHK(drv_active_o, 1'b1)
		`CHK(drv_power_down_o, 1'b0)
		repeat (3) @(posedge clk_out_o);
		#1;
		`CHK(per, time'(320))
		acc(1, 16'h0103, 8'h06); // force bit set by the host
		repeat (3) @(posedge clk_out_o);
		#1;
		`CHK(per, time'(80))
		acc(0, 16'h0103, 8'h06);
		acc(1, 16'h0102, 8'h00);
		settle();
		`CHK({drv_active_o, clk_out_o}, 2'b00)
		acc(1, 16'h0102, 8'h01);
		acc(1, 16'h0104, 8'h11);
		acc(1, 16'h0103, 8'h00);
		settle();
		`CHK({drv_active_o, clk_out_o}, 2'b01)
		acc(1, 16'h0103, 8'h03);
		settle();
		`CHK({drv_active_o, drv_power_down_o, clk_out_o}, 3'b010)
		for (int c = 0; c < 8; c++) begin
			r = 8'($urandom());
			acc(1, 16'h0105, r);
			acc(1, 16'h0104, 8'(c));
			settle();
			ok = (c == 1 || c == 2 || c == 4);
			`CHK(style_o, ok ? 3'(c) : 3'h0)
			`CHK(style_reserved_o, ~ok)
			`CHK(common_level_o, (c == 1 || c == 2) ? r[3:0] : 4'h0)
			`CHK(swing_o, (c == 1 || c == 2) ? r[6:4] : 3'h0)
			acc(0, 16'h0105, r & 8'h7f);
		end
		// zero divider value without force: output must stand still
		acc(1, 16'h0104, 8'h01);
		acc(1, 16'h0180, 8'h00);
		acc(1, 16'h0103, 8'h02);
		settle();
		n0 = out_edges;
		repeat (100) @(posedge clk_i);
		#1;
		`CHK(out_edges, n0)
		// glitchless: power-down waits for the output's falling edge
		acc(1, 16'h0180, 8'h03);
		acc(1, 16'h0104, 8'h09);
		@(posedge clk_out_o);
		acc(1, 16'h0103, 8'h03);
		settle();
		`CHK({drv_active_o, drv_power_down_o}, 2'b10)
		@(negedge clk_out_o);
		settle();
		`CHK({drv_active_o, drv_power_down_o, clk_out_o}, 3'b010)
		settle();
		`CHK(exp_q.size(), 0)
		results();
	end
endmodule // tb_output_driver_control
